// File: shared/sdl_params.svh
// Purpose: Constants for the 22-bit framed serial link pair
// Assumes: System clock of 50 ns; serial bit time is one system clock
// Notes:   Cycle counts are derived from times where a time is given
`ifndef SDL_PARAMS_SVH
`define SDL_PARAMS_SVH

`define SDL_WORD_W        22
`define SDL_FRAME_LAST    5'h18
`define SDL_DATA_FIRST    5'h01
`define SDL_DATA_LAST     5'h16
`define SDL_CLK_NS        50
`define SDL_HS_OFF_NS     1000
`define SDL_HS_OFF_CYC    ((`SDL_HS_OFF_NS + `SDL_CLK_NS - 1) / `SDL_CLK_NS)
`define SDL_DLL_LOCK_EDGES 32
`define SDL_PD_PULSE_CYC  8
`define SDL_PD_DET_CYC    4
`define SDL_PULLUP_CYC    8
`define SDL_WAKE_CYC      4
`define SDL_PU_BLANK_CYC  6'h04
`define SDL_REGEN_RISE    5'h03
`define SDL_REGEN_FALL    5'h0f
`define SDL_DATA_RST      22'h00_0000

`endif

// File: shared/sdl_pkg.sv
// Purpose: Types for the framed serial link pair
// Assumes: Constants come from sdl_params.svh
// Notes:   State encodings are written out
`default_nettype none

package sdl_pkg;

  typedef enum logic [2:0] {
    SER_OFF    = 3'b000,
    SER_LOCK   = 3'b001,
    SER_RUN    = 3'b010,
    SER_PDPULS = 3'b011,
    SER_HSOFF  = 3'b100
  } sdl_ser_state_e;

  typedef enum logic [1:0] {
    DES_OFF    = 2'b00,
    DES_SEARCH = 2'b01,
    DES_LOCK   = 2'b10,
    DES_PULLUP = 2'b11
  } sdl_des_state_e;

endpackage

`default_nettype wire

// File: design/sdl_deser.sv
// Purpose: Receiving end: aligns frames, presents words, runs error handshake
// Assumes: One serial bit per system clock; link pins are asynchronous
// Notes:   Pull-up drives both link wires high with enables low
`include "sdl_params.svh"
`default_nettype none

module sdl_deser
  import sdl_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Handshake enable, already synchronised
  input  wire logic                   hs_en,
  // Serial link
  input  wire logic                   ser_in_p_i,
  input  wire logic                   ser_in_n_i,
  output var  logic                   ser_in_p_o,
  output var  logic                   ser_in_n_o,
  output var  logic                   ser_in_p_oe_n,
  output var  logic                   ser_in_n_oe_n,
  // Parallel output
  output var  logic [`SDL_WORD_W-1:0] par_data_out,
  output var  logic                   regen_par_clk
);

  logic [1:0]             sync1_r;
  logic [1:0]             sync2_r;
  sdl_des_state_e         st_r, st_nxt;
  logic [24:0]            sh_r, sh_nxt;
  logic [4:0]             idx_r, idx_nxt;
  logic [4:0]             ph_r, ph_nxt;
  logic [3:0]             cnt_r, cnt_nxt;
  logic [2:0]             low_r, low_nxt;
  logic                   drv_r, drv_nxt;
  logic                   regen_r, regen_nxt;
  logic [`SDL_WORD_W-1:0] data_r, data_nxt;
  logic [`SDL_WORD_W-1:0] rx_word;
  logic                   p_s, n_s, valid, frame_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {ser_in_p_i, ser_in_n_i};
      sync2_r <= sync1_r;
    end
  end

  assign p_s   = sync2_r[1];
  assign n_s   = sync2_r[0];
  assign valid = p_s ^ n_s;

  // Newest bit at position 0; lead bit lands at 24
  genvar gi;
  generate
    for (gi = 0; gi < `SDL_WORD_W; gi = gi + 1) begin : g_word
      assign rx_word[gi] = sh_r[23-gi];
    end
  endgenerate

  assign frame_ok = ~sh_r[24] & (sh_r[1] == ~sh_r[2]) & (sh_r[0] == ~sh_r[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Receive state machine
  always_comb begin
    st_nxt    = st_r;
    sh_nxt    = {sh_r[23:0], p_s};
    idx_nxt   = idx_r;
    ph_nxt    = (ph_r == `SDL_FRAME_LAST) ? ph_r : 5'(ph_r + 5'h01);
    cnt_nxt   = cnt_r;
    low_nxt   = (~p_s & ~n_s) ? ((low_r == 3'h7) ? low_r : 3'(low_r + 3'h1)) : 3'h0;
    drv_nxt   = 1'b0;
    data_nxt  = data_r;
    case (st_r)
      DES_OFF: begin
        cnt_nxt = valid ? 4'(cnt_r + 4'h1) : 4'h0;
        if (valid && cnt_r == 4'(`SDL_WAKE_CYC - 1)) begin
          st_nxt  = DES_SEARCH;
          cnt_nxt = 4'h0;
        end
      end
      DES_SEARCH: begin
        if (frame_ok && valid) begin
          st_nxt   = DES_LOCK;
          idx_nxt  = 5'h01;
          data_nxt = rx_word;
          ph_nxt   = 5'h00;
        end
      end
      DES_LOCK: begin
        idx_nxt = (idx_r == `SDL_FRAME_LAST) ? 5'h00 : 5'(idx_r + 5'h01);
        if (idx_r == 5'h00) begin
          if (frame_ok) begin
            data_nxt = rx_word;
            ph_nxt   = 5'h00;
          end else if (hs_en) begin
            st_nxt  = DES_PULLUP;
            drv_nxt = 1'b1;
            cnt_nxt = 4'h0;
          end else begin
            st_nxt = DES_SEARCH;
          end
        end
      end
      DES_PULLUP: begin
        drv_nxt = 1'b1;
        cnt_nxt = 4'(cnt_r + 4'h1);
        if (cnt_r == 4'(`SDL_PULLUP_CYC - 1)) begin
          st_nxt  = DES_OFF;
          drv_nxt = 1'b0;
          cnt_nxt = 4'h0;
        end
      end
      default: begin
        st_nxt = DES_OFF;
      end
    endcase
    // Power-down pulse from the sending end
    if ((st_r == DES_SEARCH || st_r == DES_LOCK) && low_r == 3'(`SDL_PD_DET_CYC - 1)
        && ~p_s && ~n_s) begin
      st_nxt  = DES_OFF;
      cnt_nxt = 4'h0;
      drv_nxt = 1'b0;
    end
    regen_nxt = (st_nxt == DES_LOCK) && (ph_nxt >= `SDL_REGEN_RISE)
                && (ph_nxt < `SDL_REGEN_FALL);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r    <= DES_OFF;
      sh_r    <= 25'h000_0000;
      idx_r   <= 5'h00;
      ph_r    <= 5'h00;
      cnt_r   <= 4'h0;
      low_r   <= 3'h0;
      drv_r   <= 1'b0;
      regen_r <= 1'b0;
      data_r  <= `SDL_DATA_RST;
    end else begin
      st_r    <= st_nxt;
      sh_r    <= sh_nxt;
      idx_r   <= idx_nxt;
      ph_r    <= ph_nxt;
      cnt_r   <= cnt_nxt;
      low_r   <= low_nxt;
      drv_r   <= drv_nxt;
      regen_r <= regen_nxt;
      data_r  <= data_nxt;
    end
  end

  assign ser_in_p_o    = drv_r;
  assign ser_in_n_o    = drv_r;
  assign ser_in_p_oe_n = ~drv_r;
  assign ser_in_n_oe_n = ~drv_r;
  assign par_data_out  = data_r;
  assign regen_par_clk = regen_r;

endmodule

`default_nettype wire

// File: design/sdl_link_top.sv
// Purpose: Framed 22-bit serial link pair: sending end plus receiving end
// Assumes: Parallel clock and pins sampled by a 20 MHz system clock
// Notes:   Frames go back to back; each but the first after lock carries the latest captured word
`include "sdl_params.svh"
`default_nettype none

// Summary of operation
// - Capture all 22 input bits on each parallel clock rise, one word per cycle.
// - Receiver drives recovered word with regenerated clock, data valid at its rise.
// - Frame is zero lead bit, data bits 0 to 21, then two boundary bits.
// - Both boundary bits equal the inverse of data bit 21.
// - Receiver takes its timing from the serial stream, no clock wire.
// - Receiver checks boundary bits of every received word.
// - On boundary error receiver pulls link high, then powers down.
// - Sender seeing link pulled up powers down 1.0 us, then powers up.
// - After handshake power-up receiver realigns and transfer resumes.
// - Error handshake is disabled while sleep request is low.
// - Sleep request low: sender powers down, sending power-down pulse only if it was running.
// - In power-down sender stops its lock loop and releases both outputs.
// - Sleep request high: sender locks to parallel clock, starts receiver wake.
// - Sender outputs stay undriven until lock is reached after wake.
module sdl_link_top
  import sdl_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Host parallel side
  input  wire logic                   par_clk_in,
  input  wire logic [`SDL_WORD_W-1:0] par_data_in,
  input  wire logic                   sleep_request_n,
  // Sending link pins
  input  wire logic                   ser_out_p_i,
  input  wire logic                   ser_out_n_i,
  output var  logic                   ser_out_p_o,
  output var  logic                   ser_out_n_o,
  output var  logic                   ser_out_p_oe_n,
  output var  logic                   ser_out_n_oe_n,
  // Receiving link pins
  input  wire logic                   ser_in_p_i,
  input  wire logic                   ser_in_n_i,
  output var  logic                   ser_in_p_o,
  output var  logic                   ser_in_n_o,
  output var  logic                   ser_in_p_oe_n,
  output var  logic                   ser_in_n_oe_n,
  // Display parallel side
  output var  logic [`SDL_WORD_W-1:0] par_data_out,
  output var  logic                   regen_par_clk
);

  logic [`SDL_WORD_W+3:0] sync1_r;
  logic [`SDL_WORD_W+3:0] sync2_r;
  logic                   pclk_d_r;
  logic                   pu_d_r;
  sdl_ser_state_e         st_r, st_nxt;
  logic [4:0]             idx_r, idx_nxt;
  logic [5:0]             cnt_r, cnt_nxt;
  logic [`SDL_WORD_W-1:0] word_r, word_nxt;
  logic [`SDL_WORD_W-1:0] frame_r, frame_nxt;
  logic                   p_r, p_nxt;
  logic                   n_r, n_nxt;
  logic                   oe_n_r, oe_n_nxt;
  logic                   pclk_s, sleep_s, sp_s, sn_s, pclk_rise, pu_seen;
  logic [`SDL_WORD_W-1:0] din_s;
  logic [4:0]             idx_m1;
  logic                   bit_out;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_r  <= 26'h000_0000;
      sync2_r  <= 26'h000_0000;
      pclk_d_r <= 1'b0;
      pu_d_r   <= 1'b0;
    end else begin
      sync1_r  <= {par_clk_in, sleep_request_n, ser_out_p_i, ser_out_n_i, par_data_in};
      sync2_r  <= sync1_r;
      pclk_d_r <= pclk_s;
      pu_d_r   <= sp_s & sn_s;
    end
  end

  assign pclk_s    = sync2_r[`SDL_WORD_W+3];
  assign sleep_s   = sync2_r[`SDL_WORD_W+2];
  assign sp_s      = sync2_r[`SDL_WORD_W+1];
  assign sn_s      = sync2_r[`SDL_WORD_W];
  assign din_s     = sync2_r[`SDL_WORD_W-1:0];
  assign pclk_rise = pclk_s & ~pclk_d_r;
  // Both wires high twice in a row: once own drive is seen, only the far end's pull-up does that
  assign pu_seen   = sp_s & sn_s & pu_d_r;
  assign idx_m1    = 5'(idx_r - `SDL_DATA_FIRST);

  ////////////////////////////////////////////////////////////////////////////
  // Frame bit selection
  always_comb begin
    if (idx_r == 5'h00) begin
      bit_out = 1'b0;
    end else if (idx_r <= `SDL_DATA_LAST) begin
      bit_out = frame_r[idx_m1];
    end else begin
      bit_out = ~frame_r[`SDL_WORD_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sending state machine
  always_comb begin
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    cnt_nxt   = cnt_r;
    frame_nxt = frame_r;
    word_nxt  = pclk_rise ? din_s : word_r;
    p_nxt     = 1'b0;
    n_nxt     = 1'b0;
    oe_n_nxt  = 1'b1;
    case (st_r)
      SER_OFF: begin
        if (sleep_s) begin
          st_nxt  = SER_LOCK;
          cnt_nxt = 6'h00;
        end
      end
      SER_LOCK: begin
        // Lock loop modelled as a run of parallel clock edges; outputs released
        if (!sleep_s) begin
          st_nxt = SER_OFF;
        end else if (pclk_rise) begin
          cnt_nxt = 6'(cnt_r + 6'h01);
          if (cnt_r == 6'(`SDL_DLL_LOCK_EDGES - 1)) begin
            st_nxt  = SER_RUN;
            idx_nxt = 5'h00;
            cnt_nxt = 6'h00;
          end
        end
      end
      SER_RUN: begin
        oe_n_nxt = 1'b0;
        p_nxt    = bit_out;
        n_nxt    = ~bit_out;
        idx_nxt  = (idx_r == `SDL_FRAME_LAST) ? 5'h00 : 5'(idx_r + 5'h01);
        // Idle bias looks like a pull-up until own drive clears the synchroniser
        cnt_nxt  = (cnt_r == `SDL_PU_BLANK_CYC) ? cnt_r : 6'(cnt_r + 6'h01);
        if (idx_r == `SDL_FRAME_LAST) begin
          frame_nxt = word_nxt;
        end
        if (!sleep_s) begin
          st_nxt   = SER_PDPULS;
          cnt_nxt  = 6'h00;
          p_nxt    = 1'b0;
          n_nxt    = 1'b0;
        end else if (pu_seen && cnt_r == `SDL_PU_BLANK_CYC) begin
          st_nxt   = SER_HSOFF;
          cnt_nxt  = 6'h00;
          oe_n_nxt = 1'b1;
        end
      end
      SER_PDPULS: begin
        // Both wires low tells the far end to power down
        oe_n_nxt = 1'b0;
        cnt_nxt  = 6'(cnt_r + 6'h01);
        if (cnt_r == 6'(`SDL_PD_PULSE_CYC - 1)) begin
          st_nxt   = SER_OFF;
          oe_n_nxt = 1'b1;
        end
      end
      SER_HSOFF: begin
        cnt_nxt = 6'(cnt_r + 6'h01);
        if (!sleep_s) begin
          st_nxt = SER_OFF;
        end else if (cnt_r == 6'(`SDL_HS_OFF_CYC - 1)) begin
          st_nxt    = SER_RUN;
          idx_nxt   = 5'h00;
          cnt_nxt   = 6'h00;
          frame_nxt = word_nxt;
        end
      end
      default: begin
        st_nxt = SER_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_r    <= SER_OFF;
      idx_r   <= 5'h00;
      cnt_r   <= 6'h00;
      word_r  <= `SDL_DATA_RST;
      frame_r <= `SDL_DATA_RST;
      p_r     <= 1'b0;
      n_r     <= 1'b0;
      oe_n_r  <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      cnt_r   <= cnt_nxt;
      word_r  <= word_nxt;
      frame_r <= frame_nxt;
      p_r     <= p_nxt;
      n_r     <= n_nxt;
      oe_n_r  <= oe_n_nxt;
    end
  end

  assign ser_out_p_o    = p_r;
  assign ser_out_n_o    = n_r;
  assign ser_out_p_oe_n = oe_n_r;
  assign ser_out_n_oe_n = oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receiving end
  sdl_deser u_deser (
    .clock         (clock),
    .rst           (rst),
    .hs_en         (sleep_s),
    .ser_in_p_i    (ser_in_p_i),
    .ser_in_n_i    (ser_in_n_i),
    .ser_in_p_o    (ser_in_p_o),
    .ser_in_n_o    (ser_in_n_o),
    .ser_in_p_oe_n (ser_in_p_oe_n),
    .ser_in_n_oe_n (ser_in_n_oe_n),
    .par_data_out  (par_data_out),
    .regen_par_clk (regen_par_clk)
  );

endmodule

`default_nettype wire

// File: dv/sdl_link_chk.sv
// Purpose: Port assertions for the framed link pair
// Assumes: Parallel clock period of 400 ns
// Notes:   Bound to sdl_link_top
`include "sdl_params.svh"
`default_nettype none

module sdl_link_chk (
  // Clock and reset
  input wire logic                   clock,
  input wire logic                   rst,
  // Watched ports
  input wire logic                   sleep_request_n,
  input wire logic                   ser_out_p_o,
  input wire logic                   ser_out_n_o,
  input wire logic                   ser_out_p_oe_n,
  input wire logic                   ser_in_p_o,
  input wire logic                   ser_in_n_o,
  input wire logic                   ser_in_p_oe_n,
  input wire logic [`SDL_WORD_W-1:0] par_data_out,
  input wire logic                   regen_par_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  // Cycles spent asleep and awake
  logic [8:0] slp_r, slp_nxt, wak_r, wak_nxt;

  always_comb begin
    slp_nxt = sleep_request_n ? 9'h000 : slp_r + {8'h00, ~&slp_r};
    wak_nxt = !sleep_request_n ? 9'h000 : wak_r + {8'h00, ~&wak_r};
  end

  always_ff @(posedge clock) begin
    slp_r <= rst ? 9'h000 : slp_nxt;
    wak_r <= rst ? 9'h000 : wak_nxt;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_drive_pair: assert property (
    !ser_out_p_oe_n |-> (ser_out_p_o != ser_out_n_o) || !(ser_out_p_o || ser_out_n_o))
    else $error("Link drive not complementary");
  a_pulse_low: assert property (
    $rose(ser_out_p_oe_n) && !sleep_request_n |-> !$past(ser_out_p_oe_n, 8)
      && !$past(ser_out_p_o, 8) && !$past(ser_out_n_o, 8))
    else $error("No low pulse before release");
  a_sleep_off: assert property (
    slp_r > 9'h010 |-> ser_out_p_oe_n)
    else $error("Sender drives while asleep");
  a_hs_gated: assert property (
    slp_r > 9'h00c |-> ser_in_p_oe_n)
    else $error("Pull-up while asleep");
  a_pullup_len: assert property (
    $fell(ser_in_p_oe_n) |-> (ser_in_p_o && ser_in_n_o && !ser_in_p_oe_n) [*8]
      ##1 ser_in_p_oe_n)
    else $error("Pull-up shape wrong");
  a_hs_restart: assert property (
    $rose(ser_out_p_oe_n) && sleep_request_n |-> ser_out_p_oe_n [*8]
      ##1 ser_out_p_oe_n [*8] ##[3:6] !ser_out_p_oe_n)
    else $error("Handshake off time wrong");
  a_lock_wait: assert property (
    sleep_request_n && wak_r < 9'h0c8 |-> ser_out_p_oe_n)
    else $error("Sender drives before lock");
  a_regen_width: assert property (
    $rose(regen_par_clk) |-> regen_par_clk [*8] ##1 regen_par_clk [*4] ##1 !regen_par_clk)
    else $error("Regenerated clock width wrong");
  a_data_hold: assert property (
    regen_par_clk |-> $stable(par_data_out))
    else $error("Data moves while clock high");

  c_pullup: cover property ($fell(ser_in_p_oe_n));
  c_release: cover property ($rose(ser_out_p_oe_n));
  c_regen: cover property ($rose(regen_par_clk));
endmodule

bind sdl_link_top sdl_link_chk u_sdl_link_chk (
  .clock, .rst, .sleep_request_n, .ser_out_p_o, .ser_out_n_o, .ser_out_p_oe_n,
  .ser_in_p_o, .ser_in_n_o, .ser_in_p_oe_n, .par_data_out, .regen_par_clk
);

`default_nettype wire

// File: dv/sdl_host_model.sv
// Purpose: Host clock and link wires around the link pair
// Assumes: Released link rests with both wires high
// Notes:   Fault holds wire_p high and wire_n low to break framing
`default_nettype none

module sdl_host_model (
  // Fault command
  input  wire logic fault,
  // Both ends' drive
  input  wire logic ser_out_p_o,
  input  wire logic ser_out_n_o,
  input  wire logic ser_out_p_oe_n,
  input  wire logic ser_out_n_oe_n,
  input  wire logic ser_in_p_o,
  input  wire logic ser_in_n_o,
  input  wire logic ser_in_p_oe_n,
  input  wire logic ser_in_n_oe_n,
  // Wires and host clock
  output wire logic wire_p,
  output wire logic wire_n,
  output var  logic par_clk_in
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    par_clk_in = 1'b0;
    #37;
    forever #200 par_clk_in = ~par_clk_in;
  end

  // Pull-up wins, then fault, then sender, then bias
  assign wire_p = !ser_in_p_oe_n ? ser_in_p_o : fault ? 1'b1 :
                  !ser_out_p_oe_n ? ser_out_p_o : 1'b1;
  assign wire_n = !ser_in_n_oe_n ? ser_in_n_o : fault ? 1'b0 :
                  !ser_out_n_oe_n ? ser_out_n_o : 1'b1;
endmodule

`default_nettype wire

// File: dv/testbench.sv
// Purpose: Self-checking bench for the framed link pair
// Assumes: Sender looped to receiver through the wire model
// Notes:   Word table, then handshake, sleep and wake cases
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [21:0] din;
    logic [24:0] frame;
  } sdl_row_s;

  logic        clock, rst, sleep_request_n, fault, par_clk_in, wire_p, wire_n;
  logic [21:0] par_data_in, par_data_out;
  logic        ser_out_p_o, ser_out_n_o, ser_out_p_oe_n, ser_out_n_oe_n;
  logic        ser_in_p_o, ser_in_n_o, ser_in_p_oe_n, ser_in_n_oe_n, regen_par_clk;
  logic [24:0] sh_r, frm;
  logic        hit, pulse_seen, pull_seen, clr;
  int          error_cnt, tests_run;
  sdl_row_s    rows [6] = '{'{22'h2a_aaaa, 25'h055_5554}, '{22'h15_5555, 25'h1aa_aaaa},
                           '{22'h3f_ffff, 25'h07f_fffe}, '{22'h00_0000, 25'h180_0000},
                           '{22'h20_0001, 25'h040_0002}, '{22'h1f_fffe, 25'h1bf_fffc}};

  sdl_link_top u_sdl_link_top (
    .clock, .rst, .par_clk_in, .par_data_in, .sleep_request_n,
    .ser_out_p_i(wire_p), .ser_out_n_i(wire_n), .ser_out_p_o, .ser_out_n_o,
    .ser_out_p_oe_n, .ser_out_n_oe_n, .ser_in_p_i(wire_p), .ser_in_n_i(wire_n),
    .ser_in_p_o, .ser_in_n_o, .ser_in_p_oe_n, .ser_in_n_oe_n, .par_data_out, .regen_par_clk);

  sdl_host_model u_sdl_host_model (
    .fault, .ser_out_p_o, .ser_out_n_o, .ser_out_p_oe_n, .ser_out_n_oe_n, .ser_in_p_o,
    .ser_in_n_o, .ser_in_p_oe_n, .ser_in_n_oe_n, .wire_p, .wire_n, .par_clk_in);

  ////////////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    sh_r <= {ser_out_p_o, sh_r[24:1]};
    if (clr) begin
      hit        <= 1'b0;
      pulse_seen <= 1'b0;
      pull_seen  <= 1'b0;
    end else begin
      if (sh_r == frm)
        hit <= 1'b1;
      if (!ser_out_p_oe_n && !ser_out_p_o && !ser_out_n_o)
        pulse_seen <= 1'b1;
      if (!ser_in_p_oe_n)
        pull_seen <= 1'b1;
    end
  end

  task automatic clear_flags();
    clr = 1'b1;
    @(negedge clock);
    clr = 1'b0;
  endtask

  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wait_for(input int sel, input logic val, input int lim);
    logic s;
    for (int i = 0; i <= lim; i++) begin
      @(negedge clock);
      s = sel == 0 ? ser_in_p_oe_n : sel == 1 ? ser_out_p_oe_n : regen_par_clk;
      if (s === val)
        return;
    end
    error_cnt++;
    $display("unexpected at %0t: wait %0d ran out", $time, sel);
    print_verdict();
  endtask

  task automatic send(input logic [21:0] w);
    @(negedge par_clk_in);
    @(negedge clock);
    par_data_in = w;
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    sleep_request_n = 1'b1;
    fault = 1'b0;
    par_data_in = 22'h00_0000;
    frm = 25'h000_0000;
    clr = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    repeat (5) @(negedge clock);
    check({ser_out_p_oe_n, ser_in_p_oe_n, regen_par_clk, par_data_out}, 25'h180_0000);
    check({ser_out_n_oe_n, ser_in_n_oe_n, ser_in_p_o, ser_in_n_o, ser_out_p_o, ser_out_n_o},
          25'h000_0030);
    rst = 1'b0;
    clr = 1'b0;
    wait_for(1, 1'b0, 400);
    foreach (rows[i]) begin
      send(rows[i].din);
      frm = rows[i].frame;
      clear_flags();
      repeat (100) @(negedge clock);
      check(hit, 1'b1);
      wait_for(2, 1'b0, 30);
      wait_for(2, 1'b1, 30);
      check(par_data_out, rows[i].din);
    end
    // Broken framing with sleep high
    fault = 1'b1;
    wait_for(0, 1'b0, 80);
    wait_for(1, 1'b1, 12);
    fault = 1'b0;
    send(22'h0a_5a5a);
    wait_for(1, 1'b0, 30);
    repeat (150) @(negedge clock);
    check(par_data_out, 22'h0a_5a5a);
    // Sleep, then broken framing while asleep
    sleep_request_n = 1'b0;
    clear_flags();
    // Break framing before the pulse reaches the wire; receiver still locked
    @(negedge clock);
    fault = 1'b1;
    wait_for(1, 1'b1, 20);
    check(pulse_seen, 1'b1);
    repeat (100) @(negedge clock);
    fault = 1'b0;
    check(pull_seen, 1'b0);
    // Wake with the host clock running
    send(22'h33_0cc3);
    sleep_request_n = 1'b1;
    repeat (150) @(negedge clock);
    check(ser_out_p_oe_n, 1'b1);
    wait_for(1, 1'b0, 200);
    repeat (4096) @(posedge par_clk_in);
    wait_for(2, 1'b1, 30);
    check(par_data_out, 22'h33_0cc3);
    print_verdict();
  end
endmodule

`default_nettype wire
